// >>> logic/link_supervisor_pkg.sv
// Constants and carrier types for the serial link supervisor
package link_supervisor_pkg;

	// APB register byte addresses
	localparam logic [7:0] ADDR_LINK_CFG = 8'h00;
	localparam logic [7:0] ADDR_GAP_LIMIT = 8'h04;
	localparam logic [7:0] ADDR_OUT_RANGE = 8'h08;
	localparam logic [7:0] ADDR_ALERT_CFG = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h10;

	// Field limits and reset values
	localparam logic [7:0] STATION_MAX = 8'hc7;
	localparam logic [7:0] STATION_WILD = 8'hff;
	localparam logic [7:0] STATION_BCAST = 8'h00;
	localparam logic [7:0] STATION_RST = 8'h01;
	localparam logic [2:0] RATE_SEL_RST = 3'h3;
	localparam logic [2:0] REPLY_EXTRA_DELAY_SEL_RST = 3'h0;
	localparam logic [6:0] GAP_LIMIT_MAX = 7'h63;
	localparam logic [6:0] GAP_LIMIT_RST = 7'h00;
	localparam logic [15:0] OUT_LO_RST = 16'h0000;
	localparam logic [15:0] OUT_HI_RST = 16'hffff;
	localparam logic [15:0] ALERT_CODE_RST = 16'h0000;

	// Character layout and framing
	localparam int unsigned CHAR_BITS = 11;
	localparam int unsigned SILENCE_BITS = 39;
	localparam logic [7:0] MIN_FRAME_BYTES = 8'h04;
	localparam logic [15:0] CRC_INIT = 16'hffff;
	localparam logic [15:0] CRC_POLY = 16'ha001;

	// Function codes and always-open registers
	localparam logic [7:0] FUNC_WRITE_ONE = 8'h06;
	localparam logic [7:0] FUNC_WRITE_MANY = 8'h10;
	localparam logic [15:0] REG_OPEN_A = 16'h0004;
	localparam logic [15:0] REG_OPEN_B = 16'h0005;

	// Line rates and reply delays in characters
	localparam int unsigned LINE_RATE [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600,
		115200};
	localparam int unsigned REPLY_EXTRA_DELAY_CHARS [5] = '{0, 10, 20, 50, 100};

	typedef struct packed {
		logic valid;
		logic for_us;
		logic bcast;
		logic wr_allowed;
		logic [7:0] func;
		logic [15:0] reg_addr;
	} frame_info_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} reply_t;

endpackage

// >>> logic/serial_slave_link_supervisor.sv
// Serial slave link supervisor: framing, address match, write gating, watchdog, reply pacing
`timescale 1ns/1ps

// Behaviour
// - Answer only own station address, 0..199
// - Station zero answers address 255
// - Eight selectable line rates
// - Permit off blocks remote configuration writes
// - Registers 04h, 05h always writable
// - Frame gap overrun forces alert outputs
// - Gap limit 0..99 s, zero disables
// - Standard delay answers at once
// - Extra 10/20/50/100 character reply delay
// - Analogue code saturates at range borders
// - 8N1/8N2 received, 8N2 sent
// - Broadcasts acted on, never answered
// - Resumed frames clear the alert
module serial_slave_link_supervisor #(
	parameter int unsigned CLK_HZ = 10000000
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rx_pin,
	output logic tx_pin,
	output logic tx_drive_en,
	output link_supervisor_pkg::frame_info_t frame_info,
	input wire link_supervisor_pkg::reply_t reply,
	output logic reply_ready,
	input wire logic [15:0] calc_code,
	input wire logic [1:0] relay_req,
	output logic [15:0] out_code,
	output logic [1:0] relay_out
);

	typedef struct packed {
		logic rx_s1;
		logic rx_s2;
		logic rx_busy;
		logic [23:0] rx_cnt;
		logic [3:0] rx_bit;
		logic [7:0] rx_sh;
		logic [23:0] sil_cnt;
		logic frm_open;
		logic frm_err;
		logic [7:0] byte_n;
		logic [15:0] crc;
		logic [7:0] f_addr;
		logic [7:0] f_func;
		logic [7:0] f_reg_hi;
		logic [7:0] f_reg_lo;
		link_supervisor_pkg::frame_info_t finfo;
		logic [31:0] sec_cnt;
		logic [6:0] gap_s;
		logic alert;
		logic rsp_arm;
		logic rsp_drop;
		logic [31:0] dly_cnt;
		logic tx_busy;
		logic [23:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [10:0] tx_sh;
		logic tx_line;
		logic [7:0] station;
		logic [2:0] rate_sel;
		logic permit;
		logic [2:0] reply_extra_delay_sel;
		logic [6:0] gap_limit;
		logic [15:0] out_lo;
		logic [15:0] out_hi;
		logic [15:0] alert_code;
		logic [1:0] relay_alert;
		logic ana_link;
		logic [1:0] relay_link;
		logic [15:0] out_code;
		logic [1:0] relay_out;
		logic [31:0] prdata;
	} state_t;

	state_t st_ff;
	state_t nxt_st;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ link_supervisor_pkg::CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	logic [23:0] bit_div;
	logic [23:0] half_div;
	logic [23:0] sil_lim;
	logic [31:0] dly_lim;
	logic dly_done;
	logic apb_setup;
	logic apb_wr;
	logic mapped;
	logic [7:0] ra;
	logic rx_byte;
	logic frm_end;
	logic good;
	logic for_us;
	logic bcast;
	logic is_wr;
	logic [15:0] reg_addr;
	logic reply_take;
	logic [15:0] clamped;

	always_comb begin
		bit_div = 24'((CLK_HZ + link_supervisor_pkg::LINE_RATE[st_ff.rate_sel] / 2)
			/ link_supervisor_pkg::LINE_RATE[st_ff.rate_sel]);
	end

	assign half_div = bit_div >> 1;
	assign sil_lim = 24'(bit_div * link_supervisor_pkg::SILENCE_BITS);
	assign dly_lim = (st_ff.reply_extra_delay_sel > 3'h4) ? 32'h0000_0000 :
		32'(bit_div * link_supervisor_pkg::CHAR_BITS
		* link_supervisor_pkg::REPLY_EXTRA_DELAY_CHARS[st_ff.reply_extra_delay_sel]);
	assign dly_done = st_ff.dly_cnt >= dly_lim;

	assign apb_setup = psel && !penable;
	assign apb_wr = psel && penable && pwrite;
	assign mapped = (paddr <= link_supervisor_pkg::ADDR_STATUS) && (paddr[1:0] == 2'b00);
	assign ra = st_ff.f_addr;
	assign reg_addr = {st_ff.f_reg_hi, st_ff.f_reg_lo};

	assign frm_end = st_ff.frm_open && (st_ff.sil_cnt >= sil_lim);
	assign good = !st_ff.frm_err && (st_ff.byte_n >= link_supervisor_pkg::MIN_FRAME_BYTES)
		&& (st_ff.crc == 16'h0000);
	assign for_us = (ra == st_ff.station) && (ra != link_supervisor_pkg::STATION_BCAST)
		|| ((st_ff.station == link_supervisor_pkg::STATION_BCAST)
		&& (ra == link_supervisor_pkg::STATION_WILD));
	assign bcast = ra == link_supervisor_pkg::STATION_BCAST;
	assign is_wr = (st_ff.f_func == link_supervisor_pkg::FUNC_WRITE_ONE)
		|| (st_ff.f_func == link_supervisor_pkg::FUNC_WRITE_MANY);

	assign reply_ready = st_ff.rsp_drop || (st_ff.rsp_arm && dly_done && !st_ff.tx_busy);
	assign reply_take = reply.valid && reply_ready;

	assign clamped = (calc_code < st_ff.out_lo) ? st_ff.out_lo :
		(calc_code > st_ff.out_hi) ? st_ff.out_hi : calc_code;

	assign rx_byte = st_ff.rx_busy && (st_ff.rx_cnt >= bit_div - 24'h00_0001)
		&& (st_ff.rx_bit == 4'h9);

	always_comb begin
		nxt_st = st_ff;
		nxt_st.finfo.valid = 1'b0;

		// Receiver: sample at mid bit, one stop bit checked
		nxt_st.rx_s1 = rx_pin;
		nxt_st.rx_s2 = st_ff.rx_s1;
		if (!st_ff.rx_busy) begin
			if (!st_ff.rx_s2) begin
				nxt_st.rx_busy = 1'b1;
				nxt_st.rx_cnt = half_div;
				nxt_st.rx_bit = 4'h0;
			end
		end else if (st_ff.rx_cnt >= bit_div - 24'h00_0001) begin
			nxt_st.rx_cnt = 24'h00_0000;
			nxt_st.rx_bit = st_ff.rx_bit + 4'h1;
			if (st_ff.rx_bit == 4'h0 && st_ff.rx_s2) begin
				nxt_st.rx_busy = 1'b0;
			end else if (st_ff.rx_bit >= 4'h1 && st_ff.rx_bit <= 4'h8) begin
				nxt_st.rx_sh = {st_ff.rx_s2, st_ff.rx_sh[7:1]};
			end else if (st_ff.rx_bit == 4'h9) begin
				nxt_st.rx_busy = 1'b0;
				if (!st_ff.rx_s2) begin
					nxt_st.frm_err = 1'b1;
				end
			end
		end else begin
			nxt_st.rx_cnt = st_ff.rx_cnt + 24'h00_0001;
		end

		// Frame assembly
		if (st_ff.rx_busy || !st_ff.rx_s2) begin
			nxt_st.sil_cnt = 24'h00_0000;
		end else if (st_ff.sil_cnt < sil_lim) begin
			nxt_st.sil_cnt = st_ff.sil_cnt + 24'h00_0001;
		end
		if (rx_byte && st_ff.rx_s2) begin
			nxt_st.frm_open = 1'b1;
			nxt_st.crc = crc_step(st_ff.crc, st_ff.rx_sh);
			if (st_ff.byte_n != 8'hff) begin
				nxt_st.byte_n = st_ff.byte_n + 8'h01;
			end
			case (st_ff.byte_n)
				8'h00: nxt_st.f_addr = st_ff.rx_sh;
				8'h01: nxt_st.f_func = st_ff.rx_sh;
				8'h02: nxt_st.f_reg_hi = st_ff.rx_sh;
				8'h03: nxt_st.f_reg_lo = st_ff.rx_sh;
				default: nxt_st.f_reg_lo = st_ff.f_reg_lo;
			endcase
		end
		if (frm_end) begin
			nxt_st.frm_open = 1'b0;
			nxt_st.frm_err = 1'b0;
			nxt_st.byte_n = 8'h00;
			nxt_st.crc = link_supervisor_pkg::CRC_INIT;
			nxt_st.finfo.valid = good && (for_us || bcast);
			nxt_st.finfo.for_us = for_us;
			nxt_st.finfo.bcast = bcast;
			nxt_st.finfo.func = st_ff.f_func;
			nxt_st.finfo.reg_addr = reg_addr;
			// registers 04h and 05h stay open
			nxt_st.finfo.wr_allowed = is_wr && (st_ff.permit
				|| reg_addr == link_supervisor_pkg::REG_OPEN_A
				|| reg_addr == link_supervisor_pkg::REG_OPEN_B);
		end

		if (st_ff.sec_cnt >= CLK_HZ - 1) begin
			nxt_st.sec_cnt = 32'h0000_0000;
			if (st_ff.gap_s != 7'h7f) begin
				nxt_st.gap_s = st_ff.gap_s + 7'h01;
			end
		end else begin
			nxt_st.sec_cnt = st_ff.sec_cnt + 32'h0000_0001;
		end
		nxt_st.alert = (st_ff.gap_limit != 7'h00) && (nxt_st.gap_s > st_ff.gap_limit);
		if (st_ff.rsp_arm && !dly_done) begin
			nxt_st.dly_cnt = st_ff.dly_cnt + 32'h0000_0001;
		end
		if (reply_take && reply.last) begin
			nxt_st.rsp_arm = 1'b0;
			nxt_st.rsp_drop = 1'b0;
		end
		if (st_ff.finfo.valid) begin
			nxt_st.sec_cnt = 32'h0000_0000;
			nxt_st.gap_s = 7'h00;
			nxt_st.alert = 1'b0;
			nxt_st.dly_cnt = 32'h0000_0000;
			nxt_st.rsp_drop = st_ff.finfo.bcast;
			nxt_st.rsp_arm = !st_ff.finfo.bcast;
		end

		if (reply_take && !st_ff.rsp_drop) begin
			nxt_st.tx_busy = 1'b1;
			nxt_st.tx_sh = {2'b11, reply.data, 1'b0};
			nxt_st.tx_cnt = 24'h00_0000;
			nxt_st.tx_bit = 4'h0;
		end else if (st_ff.tx_busy) begin
			if (st_ff.tx_cnt >= bit_div - 24'h00_0001) begin
				nxt_st.tx_cnt = 24'h00_0000;
				nxt_st.tx_sh = {1'b1, st_ff.tx_sh[10:1]};
				nxt_st.tx_bit = st_ff.tx_bit + 4'h1;
				if (st_ff.tx_bit == 4'(link_supervisor_pkg::CHAR_BITS - 1)) begin
					nxt_st.tx_busy = 1'b0;
				end
			end else begin
				nxt_st.tx_cnt = st_ff.tx_cnt + 24'h00_0001;
			end
		end
		nxt_st.tx_line = nxt_st.tx_busy ? nxt_st.tx_sh[0] : 1'b1;

		nxt_st.out_code = (st_ff.alert && st_ff.ana_link) ? st_ff.alert_code : clamped;
		for (int i = 0; i < 2; i++) begin
			nxt_st.relay_out[i] = (st_ff.alert && st_ff.relay_link[i]) ?
				st_ff.relay_alert[i] : relay_req[i];
		end

		// APB register access
		if (apb_setup) begin
			case (paddr)
				link_supervisor_pkg::ADDR_LINK_CFG: nxt_st.prdata = {17'h0_0000,
					st_ff.reply_extra_delay_sel, st_ff.permit, st_ff.rate_sel, st_ff.station};
				link_supervisor_pkg::ADDR_GAP_LIMIT: nxt_st.prdata = {25'h000_0000,
					st_ff.gap_limit};
				link_supervisor_pkg::ADDR_OUT_RANGE: nxt_st.prdata = {st_ff.out_hi,
					st_ff.out_lo};
				link_supervisor_pkg::ADDR_ALERT_CFG: nxt_st.prdata = {11'h000,
					st_ff.relay_link, st_ff.ana_link, st_ff.relay_alert, st_ff.alert_code};
				link_supervisor_pkg::ADDR_STATUS: nxt_st.prdata = {8'h00, st_ff.rsp_arm,
					st_ff.gap_s, st_ff.f_addr, 7'h00, st_ff.alert};
				default: nxt_st.prdata = 32'h0000_0000;
			endcase
		end
		if (apb_wr) begin
			case (paddr)
				link_supervisor_pkg::ADDR_LINK_CFG: begin
					if (pwdata[7:0] <= link_supervisor_pkg::STATION_MAX) begin
						nxt_st.station = pwdata[7:0];
					end
					nxt_st.rate_sel = pwdata[10:8];
					nxt_st.permit = pwdata[11];
					nxt_st.reply_extra_delay_sel = pwdata[14:12];
				end
				link_supervisor_pkg::ADDR_GAP_LIMIT: begin
					if (pwdata[6:0] <= link_supervisor_pkg::GAP_LIMIT_MAX
						&& pwdata[31:7] == 25'h000_0000) begin
						nxt_st.gap_limit = pwdata[6:0];
					end
				end
				link_supervisor_pkg::ADDR_OUT_RANGE: begin
					nxt_st.out_lo = pwdata[15:0];
					nxt_st.out_hi = pwdata[31:16];
				end
				link_supervisor_pkg::ADDR_ALERT_CFG: begin
					nxt_st.alert_code = pwdata[15:0];
					nxt_st.relay_alert = pwdata[17:16];
					nxt_st.ana_link = pwdata[18];
					nxt_st.relay_link = pwdata[20:19];
				end
				default: nxt_st.prdata = st_ff.prdata;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.rx_s1 <= 1'b1;
			st_ff.rx_s2 <= 1'b1;
			st_ff.crc <= link_supervisor_pkg::CRC_INIT;
			st_ff.tx_line <= 1'b1;
			st_ff.station <= link_supervisor_pkg::STATION_RST;
			st_ff.rate_sel <= link_supervisor_pkg::RATE_SEL_RST;
			st_ff.reply_extra_delay_sel <= link_supervisor_pkg::REPLY_EXTRA_DELAY_SEL_RST;
			st_ff.gap_limit <= link_supervisor_pkg::GAP_LIMIT_RST;
			st_ff.out_lo <= link_supervisor_pkg::OUT_LO_RST;
			st_ff.out_hi <= link_supervisor_pkg::OUT_HI_RST;
			st_ff.alert_code <= link_supervisor_pkg::ALERT_CODE_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pready = psel && penable;
	assign pslverr = psel && penable && !mapped;
	assign prdata = st_ff.prdata;
	assign tx_pin = st_ff.tx_line;
	assign tx_drive_en = st_ff.tx_busy;
	assign frame_info = st_ff.finfo;
	assign out_code = st_ff.out_code;
	assign relay_out = st_ff.relay_out;

endmodule

// >>> sim/link_sup_sva.sv
// Port assertions for the serial link supervisor
`timescale 1ns/1ps
module link_sup_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_pin,
	input wire logic tx_drive_en,
	input wire link_supervisor_pkg::frame_info_t frame_info
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic acc;
	logic hit;
	logic fv;
	assign acc = psel && penable;
	assign hit = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	assign fv = frame_info.valid;
	sequence start_s;
		!tx_pin ##1 !tx_pin;
	endsequence
	a_ready_access: assert property (acc |-> pready)
		else $error("pready low in access");
	a_unmapped_err: assert property (acc && !hit && !pwrite |-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped read not refused");
	a_mapped_ok: assert property (acc && hit |-> !pslverr)
		else $error("mapped access refused");
	a_bcast_alone: assert property (fv && frame_info.bcast |-> !frame_info.for_us)
		else $error("broadcast marked as own");
	a_write_func: assert property (fv && !(frame_info.func inside {8'h06, 8'h10}) |-> !frame_info.wr_allowed)
		else $error("non-write function allowed");
	a_open_regs: assert property (fv && frame_info.func == 8'h06 && frame_info.reg_addr inside {16'h0004, 16'h0005} |-> frame_info.wr_allowed)
		else $error("open register blocked");
	a_line_idle: assert property (!tx_drive_en |-> tx_pin)
		else $error("line not idle high");
	a_start_bit: assert property ($rose(tx_drive_en) |-> start_s)
		else $error("missing start bit");
endmodule

bind serial_slave_link_supervisor link_sup_sva sva_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_pin(tx_pin), .tx_drive_en(tx_drive_en), .frame_info(frame_info));

// >>> sim/serial_master_model.sv
// Serial bus master model: sends request frames, captures answer characters
`timescale 1ns/1ps
module serial_master_model #(
	parameter int BIT_DIV = 10
) (
	input wire logic pclk,
	input wire logic tx_pin,
	input wire logic tx_drive_en,
	output logic rx_pin,
	output logic [9:0] got,
	output logic got_stb
);
	initial begin
		rx_pin = 1'b1;
		got = 10'h000;
		got_stb = 1'b0;
	end
	task automatic send_req(input logic [31:0] hdr);
		logic [7:0] fr [6];
		logic [15:0] crc;
		logic [9:0] sh;
		crc = 16'hffff;
		for (int i = 0; i < 4; i++) begin
			fr[i] = hdr[31 - 8 * i -: 8];
			crc = crc ^ {8'h00, fr[i]};
			for (int k = 0; k < 8; k++) begin
				crc = crc[0] ? (crc >> 1) ^ 16'ha001 : crc >> 1;
			end
		end
		fr[4] = crc[7:0];
		fr[5] = crc[15:8];
		for (int i = 0; i < 6; i++) begin
			sh = {1'b1, fr[i], 1'b0};
			for (int k = 0; k < 10; k++) begin
				rx_pin <= sh[k];
				repeat (BIT_DIV) @(posedge pclk);
			end
		end
	endtask
	initial forever begin
		@(posedge pclk);
		if (tx_drive_en === 1'b1 && tx_pin === 1'b0) begin
			repeat (BIT_DIV / 2) @(posedge pclk);
			for (int k = 0; k < 10; k++) begin
				repeat (BIT_DIV) @(posedge pclk);
				got[k] <= tx_pin;
			end
			got_stb <= 1'b1;
			@(posedge pclk);
			got_stb <= 1'b0;
		end
	end
endmodule

// >>> sim/serial_slave_link_supervisor_tb.sv
// Self-checking bench for the serial link supervisor
`timescale 1ns/1ps
module serial_slave_link_supervisor_tb;
	localparam link_supervisor_pkg::frame_info_t FW = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h03, 16'h0001};
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_pin;
	logic tx_pin;
	logic tx_drive_en;
	link_supervisor_pkg::frame_info_t frame_info;
	link_supervisor_pkg::reply_t reply = '0;
	logic reply_ready;
	logic [15:0] calc_code = 16'h0150;
	logic [1:0] relay_req = 2'h1;
	logic [15:0] out_code;
	logic [1:0] relay_out;
	logic [9:0] got;
	logic got_stb;
	logic [32:0] r;
	logic [31:0] rv;
	logic [31:0] seed = 32'ha378_9884;
	logic [15:0] cb [4] = '{16'h00ff, 16'h0100, 16'h0200, 16'h0201};
	int rc [4] = '{10, 20, 50, 100};
	link_supervisor_pkg::frame_info_t exp_fi [$];
	logic [9:0] exp_tx [$];
	int errors = 0;
	int samples_checked = 0;
	int cyc = 0;
	int t_v = 0;
	always #50 pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	serial_slave_link_supervisor #(.CLK_HZ(12000)) dut_u (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin),
		.tx_drive_en(tx_drive_en), .frame_info(frame_info), .reply(reply),
		.reply_ready(reply_ready), .calc_code(calc_code), .relay_req(relay_req),
		.out_code(out_code), .relay_out(relay_out));
	serial_master_model #(.BIT_DIV(10)) mdl_u (.pclk(pclk), .tx_pin(tx_pin),
		.tx_drive_en(tx_drive_en), .rx_pin(rx_pin), .got(got), .got_stb(got_stb));
	task automatic chk(input logic [32:0] g, input logic [32:0] e);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("Comparisons %0d, mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			errors++;
			tally_and_finish();
		end
		r = {pslverr, prdata};
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, e);
	endtask
	// Sends a request, optionally answers it and checks the answer delay
	task automatic req(input logic [31:0] h, input link_supervisor_pkg::frame_info_t e,
		input logic ans, input int n);
		int i;
		if (e.valid) exp_fi.push_back(e);
		if (ans) reply <= {1'b1, 1'b1, h[7:0] ^ 8'h5a};
		if (ans && !e.bcast) exp_tx.push_back({2'b11, h[7:0] ^ 8'h5a});
		mdl_u.send_req(h);
		for (i = 0; ans && i < 12000; i++) begin
			@(posedge pclk);
			if (reply_ready === 1'b1) begin
				reply <= '0;
				if (!e.bcast) chk(cyc - t_v >= n * 110 && cyc - t_v <= n * 110 + 4, 1'b1);
				break;
			end
		end
		if (i == 12000) begin
			errors++;
			tally_and_finish();
		end
		repeat (600) @(posedge pclk);
	endtask
	always @(posedge pclk) begin
		if (frame_info.valid === 1'b1) begin
			t_v <= cyc;
			if (exp_fi.size() == 0) chk(frame_info, 33'h1_ffff_ffff);
			else chk(frame_info, exp_fi.pop_front());
		end
		if (got_stb === 1'b1) begin
			if (exp_tx.size() == 0) chk(got, 33'h1_ffff_ffff);
			else chk(got, exp_tx.pop_front());
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, 33'h0_0000_0301);
		rd(8'h04, 33'h0_0000_0000);
		rd(8'h08, 33'h0_ffff_0000);
		rd(8'h0c, 33'h0_0000_0000);
		rd(8'h14, 33'h1_0000_0000);
		for (int i = 7; i >= 0; i--) begin
			apb(1'b1, 8'h00, 32'h0000_0005 | 32'(i << 8));
			rd(8'h00, {1'b0, 32'h0000_0005 | 32'(i << 8)});
		end
		apb(1'b1, 8'h00, 32'h0000_00c8);
		rd(8'h00, 33'h0_0000_0005);
		apb(1'b1, 8'h04, 32'h0000_0064);
		rd(8'h04, 33'h0_0000_0000);
		$display("Registers test done");
		req(32'h0506_0004, '{1'b1, 1'b1, 1'b0, 1'b1, 8'h06, 16'h0004}, 1'b1, 0);
		req(32'h0506_0007, '{1'b1, 1'b1, 1'b0, 1'b0, 8'h06, 16'h0007}, 1'b1, 0);
		req(32'h0606_0004, '0, 1'b0, 0);
		req(32'h0010_0005, '{1'b1, 1'b0, 1'b1, 1'b1, 8'h10, 16'h0005}, 1'b1, 0);
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, 32'h0000_0805 | 32'((i + 1) << 12));
			req(i[0] ? 32'h0503_0007 : 32'h0506_0007, '{1'b1, 1'b1, 1'b0, !i[0],
				i[0] ? 8'h03 : 8'h06, 16'h0007}, 1'b1, rc[i]);
		end
		apb(1'b1, 8'h00, 32'h0000_0000);
		req(32'hff03_0001, FW, 1'b1, 0);
		$display("Frames test done");
		apb(1'b1, 8'h08, 32'h0200_0100);
		for (int i = 0; i < 12; i++) begin
			rv = xs();
			calc_code <= i < 4 ? cb[i[1:0]] : rv[15:0] & 16'h03ff;
			relay_req <= rv[17:16];
			repeat (2) @(posedge pclk);
			chk({out_code, relay_out}, {(calc_code < 16'h0100) ? 16'h0100 : (calc_code >
				16'h0200) ? 16'h0200 : calc_code, relay_req});
		end
		calc_code <= 16'h0150;
		apb(1'b1, 8'h0c, 32'h001e_abcd);
		repeat (30000) @(posedge pclk);
		chk({out_code, relay_out}, {16'h0150, relay_req});
		apb(1'b1, 8'h04, 32'h0000_0001);
		req(32'hff03_0001, FW, 1'b1, 0);
		for (int i = 0; i < 30000 && out_code !== 16'habcd; i++) @(posedge pclk);
		if (out_code !== 16'habcd) begin
			errors++;
			tally_and_finish();
		end
		chk(cyc - t_v >= 23998 && cyc - t_v <= 24008, 1'b1);
		chk({out_code, relay_out}, {16'habcd, 2'b10});
		req(32'hff03_0001, FW, 1'b1, 0);
		chk({out_code, relay_out}, {16'h0150, relay_req});
		$display("Watchdog test done");
		tally_and_finish();
	end
endmodule
